/* File: rtl/hmd_motor_drive.sv */
`timescale 1ns/100ps
`include "hmd_consts.svh"
// Operation
// - Negative command uses negative limit, positive uses positive
// - Below limit, duty follows command linearly
// - Active override uses the override current limit
// - Ramp up and down over configured durations
// - Enable off removes drive immediately, no ramp
// - Source zero is one state, above zero other
// - Invert setting swaps bridge polarity
// - Over-temperature disables drive with hysteresis release
// - Low-pass filter measured current, configurable constant
// - Direction changes after N same-sign targets
// - Dead time ties both terminals to ground
// - Combined mode decodes enable value as both
// - Combined code: off, forward, reverse, reserved
// - Current above 75A disables the drive
// - After over-current, wait for zero command
// - Drive stays off unless safe-torque-off input low
// - First proportional output gated by same input
// - Command taken from configured source and number
module hmd_motor_drive
   import hmd_pkg::*;
#(
   parameter int CTRL_CYCLES = `HMD_CTRL_CYCLES,
   parameter int NSRC = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input hmd_pkg::hmd_src_t i_src [NSRC],
   input wire logic [16:0] i_current_ma,
   input wire logic [15:0] i_temp,
   input wire logic i_safe_torque_off_input,
   input wire logic [15:0] i_prop1_duty,
   output hmd_pkg::hmd_bridge_t o_bridge,
   output logic [15:0] o_prop1_duty,
   output logic o_fault
);
   import hmd_pkg::*;

   localparam logic signed [16:0] FULL = 17'(`HMD_FULL_SCALE);

   logic [2:0] ctrl_q;
   logic [15:0] src_q;
   logic [15:0] lim_neg_q;
   logic [15:0] lim_pos_q;
   logic [15:0] lim_ovr_q;
   logic [15:0] ramp_up_q;
   logic [15:0] ramp_dn_q;
   logic [15:0] temp_max_q;
   logic [15:0] temp_hys_q;
   logic [3:0] filt_q;
   logic [7:0] stable_q;

   // Register writes
   // Unmapped indexes fall through the default and are ignored
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= 3'h0;
         src_q <= `HMD_RST_SRC;
         lim_neg_q <= `HMD_RST_LIM;
         lim_pos_q <= `HMD_RST_LIM;
         lim_ovr_q <= `HMD_RST_LIM;
         ramp_up_q <= `HMD_RST_RAMP;
         ramp_dn_q <= `HMD_RST_RAMP;
         temp_max_q <= `HMD_RST_TEMP_MAX;
         temp_hys_q <= `HMD_RST_TEMP_HYS;
         filt_q <= `HMD_RST_FILT;
         stable_q <= `HMD_RST_STABLE;
      end else if (i_wr) begin
         case (i_addr)
            `HMD_REG_CTRL: ctrl_q <= i_wdata[2:0];
            `HMD_REG_SRC: src_q <= i_wdata[15:0];
            `HMD_REG_LIM_NEG: lim_neg_q <= i_wdata[15:0];
            `HMD_REG_LIM_POS: lim_pos_q <= i_wdata[15:0];
            `HMD_REG_LIM_OVR: lim_ovr_q <= i_wdata[15:0];
            `HMD_REG_RAMP: begin
               ramp_up_q <= i_wdata[15:0];
               ramp_dn_q <= i_wdata[31:16];
            end
            `HMD_REG_TEMP: begin
               temp_max_q <= i_wdata[15:0];
               temp_hys_q <= i_wdata[31:16];
            end
            `HMD_REG_FILT: begin
               filt_q <= i_wdata[3:0];
               stable_q <= i_wdata[15:8];
            end
            default: ;
         endcase
      end
   end

   // Control cycle tick
   // Simulation shortens the period through the parameter, not the logic
   logic [31:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == 32'(CTRL_CYCLES - 1));
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt_q <= 32'h0;
      end else begin
         tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      end
   end

   // Safe-torque-off pin from outside the clock domain
   // The synchroniser starts high, so drive stays off until the pin is seen low
   logic safe_level;
   hmd_sync u_safe_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_pin(i_safe_torque_off_input),
      .i_reset_level(1'b1),
      .o_level(safe_level)
   );
   logic safe_ok;
   assign safe_ok = !safe_level;

   // Filtered current
   // Filter runs every clock, so its constant counts clock periods
   logic [16:0] cur_filt;
   hmd_filter #(.WIDTH(17)) u_filter (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_step(1'b1),
      .i_shift(filt_q),
      .i_sample(i_current_ma),
      .o_value(cur_filt)
   );

   // Source selection by configured number
   // Only the low two bits of each number pick a source; the rest are spare
   logic signed [15:0] cmd_raw;
   logic signed [15:0] dir_raw;
   logic signed [15:0] en_raw;
   logic signed [15:0] ovr_raw;
   always_comb begin
      cmd_raw = i_src[src_q[1:0]].value;
      dir_raw = i_src[src_q[5:4]].value;
      en_raw = i_src[src_q[9:8]].value;
      ovr_raw = i_src[src_q[13:12]].value;
   end

   // Enable and direction decode
   // In separate mode negative source values count as zero, so they stop or go forward
   logic enable;
   logic dir_rev;
   hmd_comb_t comb;
   always_comb begin
      comb = hmd_comb_t'(en_raw[1:0]);
      if (ctrl_q[`HMD_CTRL_COMBINED]) begin
         case (comb)
            HMD_COMB_FWD: begin
               enable = 1'b1;
               dir_rev = 1'b0;
            end
            HMD_COMB_REV: begin
               enable = 1'b1;
               dir_rev = 1'b1;
            end
            default: begin
               enable = 1'b0;
               dir_rev = 1'b0;
            end
         endcase
         if (en_raw > 16'sh0003) enable = 1'b0;
      end else begin
         enable = (en_raw > 16'sh0000);
         dir_rev = (dir_raw > 16'sh0000);
      end
   end

   // Target: clamp command to full scale, apply direction
   // Clamping keeps the duty product inside its range
   logic signed [16:0] target;
   always_comb begin
      target = 17'(cmd_raw);
      if (target > FULL) target = FULL;
      if (target < -FULL) target = -FULL;
      if (dir_rev) target = -target;
   end

   // Over-temperature latch with hysteresis
   // Hysteresis above the maximum makes the release threshold wrap; keep it small
   logic ot_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ot_q <= 1'b0;
      end else if (i_temp > temp_max_q) begin
         ot_q <= 1'b1;
      end else if (17'(i_temp) < 17'(temp_max_q) - 17'(temp_hys_q)) begin
         ot_q <= 1'b0;
      end
   end

   // Over-current trip; released only after a zero command
   // A trip and a zero command in the same cycle leave the trip set
   logic oc_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oc_q <= 1'b0;
      end else if (i_current_ma > 17'(`HMD_OC_LIMIT_MA)) begin
         oc_q <= 1'b1;
      end else if (cmd_raw == 16'sh0000) begin
         oc_q <= 1'b0;
      end
   end

   // Active current limit
   // Override replaces both directional limits while its source is above zero
   logic [16:0] limit;
   always_comb begin
      if (ctrl_q[`HMD_CTRL_OVR_EN] && ovr_raw > 16'sh0000) begin
         limit = 17'(lim_ovr_q);
      end else if (target < 0) begin
         limit = 17'(lim_neg_q);
      end else begin
         limit = 17'(lim_pos_q);
      end
   end

   // Ramp step per control cycle from duration in cycles
   // Zero duration jumps at once; long durations still move one count per cycle
   logic [16:0] step_up;
   logic [16:0] step_dn;
   always_comb begin
      step_up = (ramp_up_q == 16'h0) ? 17'(FULL) : 17'(FULL) / 17'(ramp_up_q);
      step_dn = (ramp_dn_q == 16'h0) ? 17'(FULL) : 17'(FULL) / 17'(ramp_dn_q);
      if (step_up == 17'h0) step_up = 17'h1;
      if (step_dn == 17'h0) step_dn = 17'h1;
   end

   // Sign stability counter for direction changes
   // A zero target neither counts nor clears, so a pass through zero is free
   logic [7:0] stable_cnt_q;
   logic applied_rev_q;
   logic tgt_rev;
   assign tgt_rev = (target < 0);
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stable_cnt_q <= 8'h0;
         applied_rev_q <= 1'b0;
      end else if (tick && target != 0) begin
         if (tgt_rev == applied_rev_q) begin
            stable_cnt_q <= 8'h0;
         end else if (stable_cnt_q + 8'h1 >= stable_q) begin
            applied_rev_q <= tgt_rev;
            stable_cnt_q <= 8'h0;
         end else begin
            stable_cnt_q <= stable_cnt_q + 8'h1;
         end
      end
   end

   // Working drive magnitude, ramped; current limit pulls it back
   // Enable bypasses the ramp: the stop must act within one clock
   logic signed [16:0] drive_q;
   logic [16:0] tgt_mag;
   logic dead;
   assign dead = (tgt_rev != applied_rev_q) && target != 0;
   always_comb begin
      tgt_mag = tgt_rev ? 17'(-target) : 17'(target);
      if (dead) tgt_mag = 17'h0;
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drive_q <= '0;
      end else if (!enable) begin
         drive_q <= '0;
      end else if (tick) begin
         if (cur_filt > limit && drive_q > 0) begin
            drive_q <= drive_q - 17'sh1;
         end else if (17'(drive_q) < tgt_mag) begin
            drive_q <= (17'(drive_q) + step_up > tgt_mag) ? 17'(tgt_mag)
                       : drive_q + 17'(step_up);
         end else if (17'(drive_q) > tgt_mag) begin
            drive_q <= (17'(drive_q) < tgt_mag + step_dn) ? 17'(tgt_mag)
                       : drive_q - 17'(step_dn);
         end
      end
   end

   // Bridge outputs registered
   // Dead time brakes both legs to ground with zero duty on either diagonal
   logic run_ok;
   assign run_ok = enable && safe_ok && !ot_q && !oc_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bridge <= '0;
      end else begin
         o_bridge.enable <= run_ok;
         o_bridge.brake <= dead && run_ok;
         o_bridge.forward <= applied_rev_q ^ !ctrl_q[`HMD_CTRL_INVERT];
         // Duty linear in drive magnitude
         // Full drive maps to the top of the 16-bit duty range
         o_bridge.duty <= (run_ok && !dead) ? 16'((32'(drive_q) * 32'hFFFF)
                          / 32'(`HMD_FULL_SCALE)) : 16'h0;
      end
   end

   // Proportional output one gated by safe-torque-off
   // Same synchronised level as the bridge, so both outputs stop together
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prop1_duty <= 16'h0;
      end else begin
         o_prop1_duty <= safe_ok ? i_prop1_duty : 16'h0;
      end
   end

   assign o_fault = ot_q || oc_q;

   // Register reads, data one cycle later
   // Zero outside the read slot, so stale data never looks valid
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         case (i_addr)
            `HMD_REG_CTRL: o_rdata <= {29'h0, ctrl_q};
            `HMD_REG_SRC: o_rdata <= {16'h0, src_q};
            `HMD_REG_LIM_NEG: o_rdata <= {16'h0, lim_neg_q};
            `HMD_REG_LIM_POS: o_rdata <= {16'h0, lim_pos_q};
            `HMD_REG_LIM_OVR: o_rdata <= {16'h0, lim_ovr_q};
            `HMD_REG_RAMP: o_rdata <= {ramp_dn_q, ramp_up_q};
            `HMD_REG_TEMP: o_rdata <= {temp_hys_q, temp_max_q};
            `HMD_REG_FILT: o_rdata <= {16'h0, stable_q, 4'h0, filt_q};
            `HMD_REG_STATUS: o_rdata <= {27'h0, dead, safe_ok, applied_rev_q, oc_q, ot_q};
            `HMD_REG_CURRENT: o_rdata <= {15'h0, cur_filt};
            `HMD_REG_DRIVE: o_rdata <= {{15{drive_q[16]}}, drive_q};
            default: o_rdata <= 32'h0;
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule : hmd_motor_drive

/* File: rtl/hmd_consts.svh */
`ifndef HMD_CONSTS_SVH
`define HMD_CONSTS_SVH

// Register offsets (word index on the plain register port)
`define HMD_REG_CTRL 4'h0
`define HMD_REG_SRC 4'h1
`define HMD_REG_LIM_NEG 4'h2
`define HMD_REG_LIM_POS 4'h3
`define HMD_REG_LIM_OVR 4'h4
`define HMD_REG_RAMP 4'h5
`define HMD_REG_TEMP 4'h6
`define HMD_REG_FILT 4'h7
`define HMD_REG_STATUS 4'h8
`define HMD_REG_CURRENT 4'h9
`define HMD_REG_DRIVE 4'hA

// Control register fields
`define HMD_CTRL_INVERT 0
`define HMD_CTRL_OVR_EN 1
`define HMD_CTRL_COMBINED 2

// Source register fields
`define HMD_SRC_CMD_LSB 0
`define HMD_SRC_DIR_LSB 4
`define HMD_SRC_EN_LSB 8
`define HMD_SRC_OVR_LSB 12

// Reset values
`define HMD_RST_LIM 16'hFFFF
`define HMD_RST_SRC 16'h3210
`define HMD_RST_RAMP 16'h0064
`define HMD_RST_TEMP_MAX 16'h0064
`define HMD_RST_TEMP_HYS 16'h000A
`define HMD_RST_FILT 4'h3
`define HMD_RST_STABLE 8'h04

// Over-current trip in milliamps
`define HMD_OC_LIMIT_MA 75000
// Control cycle period in microseconds
`define HMD_CTRL_PERIOD_US 1000
`define HMD_CLK_MHZ 125
`define HMD_CTRL_CYCLES (`HMD_CTRL_PERIOD_US * `HMD_CLK_MHZ)

// Full-scale drive magnitude
`define HMD_FULL_SCALE 1000

`endif

/* File: rtl/hmd_pkg.sv */
package hmd_pkg;

   // Per-source values presented by the surrounding control-source logic
   typedef struct packed {
      logic signed [15:0] value;
      logic [3:0] number;
   } hmd_src_t;

   // Bridge leg command
   typedef struct packed {
      logic enable;
      logic forward;
      logic brake;
      logic [15:0] duty;
   } hmd_bridge_t;

   // Combined enable/direction decode
   typedef enum logic [1:0] {
      HMD_COMB_OFF = 2'h0,
      HMD_COMB_FWD = 2'h1,
      HMD_COMB_REV = 2'h2,
      HMD_COMB_RSV = 2'h3
   } hmd_comb_t;

endpackage : hmd_pkg

/* File: rtl/hmd_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser: a change counts when stages two and three agree
module hmd_sync (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_pin,
   input wire logic i_reset_level,
   output logic o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Stage one feeds stage two only
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Output moves only on agreement; starts at safe high level
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_level <= 1'b1;
      end else if (s2_q == s3_q) begin
         o_level <= s3_q;
      end
   end

   logic unused_lvl;
   assign unused_lvl = i_reset_level;
endmodule : hmd_sync

/* File: rtl/hmd_filter.sv */
`timescale 1ns/100ps
// First-order low-pass on measured current: y += (x - y) >> k
module hmd_filter #(
   parameter int WIDTH = 17
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_step,
   input wire logic [3:0] i_shift,
   input wire logic [WIDTH-1:0] i_sample,
   output logic [WIDTH-1:0] o_value
);
   logic signed [WIDTH+1:0] diff;

   // Small shift passes peaks, large shift steadies the value
   always_comb begin
      diff = $signed({2'b00, i_sample}) - $signed({2'b00, o_value});
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_value <= '0;
      end else if (i_step) begin
         o_value <= WIDTH'(o_value + WIDTH'(diff >>> i_shift));
      end
   end
endmodule : hmd_filter

/* File: test/hmd_motor_drive_sva.sv */
`timescale 1ns/100ps
// Port-level checks on the drive outputs; sees only the top module's ports
module hmd_drive_chk (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [16:0] i_current_ma,
   input wire logic i_safe_torque_off_input,
   input wire logic [15:0] i_prop1_duty,
   input hmd_pkg::hmd_bridge_t o_bridge,
   input wire logic [15:0] o_prop1_duty,
   input wire logic o_fault
);
   import hmd_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // Safe input levels held past the synchroniser lag
   sequence safe_high_s;
      i_safe_torque_off_input [*7];
   endsequence
   sequence safe_low_s;
      !i_safe_torque_off_input [*8];
   endsequence
   sequence over_current_s;
      i_current_ma > 17'h124F8;
   endsequence

   safe_drive_a: assert property (safe_high_s |-> !o_bridge.enable)
      else $error("Bridge enabled while safe input high");
   safe_prop_a: assert property (safe_high_s |-> o_prop1_duty == 16'h0000)
      else $error("Prop output driven while safe input high");
   prop_pass_a: assert property (safe_low_s |-> o_prop1_duty == $past(i_prop1_duty))
      else $error("Prop output does not follow request");
   oc_fault_a: assert property (over_current_s |-> ##[1:3] o_fault)
      else $error("No fault after over-current");
   oc_off_a: assert property (over_current_s |-> ##[1:5] !o_bridge.enable)
      else $error("Bridge still enabled after over-current");
   fault_off_a: assert property (o_fault [*3] |-> !o_bridge.enable)
      else $error("Bridge enabled during fault");
   brake_idle_a: assert property (o_bridge.brake |-> o_bridge.duty == 16'h0000)
      else $error("Duty nonzero during dead time");
   duty_gate_a: assert property (!o_bridge.enable |-> o_bridge.duty == 16'h0000)
      else $error("Duty nonzero while bridge disabled");
   rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("Read data outside read slot");
endmodule : hmd_drive_chk

bind hmd_motor_drive hmd_drive_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_current_ma(i_current_ma), .o_bridge(o_bridge), .o_fault(o_fault),
   .i_safe_torque_off_input(i_safe_torque_off_input), .i_prop1_duty(i_prop1_duty),
   .o_prop1_duty(o_prop1_duty));

/* File: test/hmd_bridge_model.sv */
`timescale 1ns/100ps
// Power stage: current tracks applied duty; temperature is set by the bench
module hmd_bridge_model (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input hmd_pkg::hmd_bridge_t i_bridge,
   input wire logic i_short,
   input wire logic [15:0] i_heat,
   output logic [16:0] o_current_ma,
   output logic [15:0] o_temp
);
   import hmd_pkg::*;

   // Braked or disabled legs carry no current; a short forces a trip level
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_current_ma <= 17'h00000;
         o_temp <= 16'h0000;
      end else begin
         o_temp <= i_heat;
         if (i_short) begin
            o_current_ma <= 17'h13880;
         end else if (i_bridge.enable && !i_bridge.brake) begin
            // Full duty draws ten amps, well under the trip level
            o_current_ma <= 17'((32'(i_bridge.duty) * 32'h00002710) / 32'h0000FFFF);
         end else begin
            o_current_ma <= 17'h00000;
         end
      end
   end
endmodule : hmd_bridge_model

/* File: test/tb.sv */
`timescale 1ns/100ps
`include "hmd_consts.svh"
module tb;
   import hmd_pkg::*;
   localparam int CT = 8;
   logic clk, rst_n, wr_q, rd_q, safe_in, shrt, fault;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   hmd_src_t src [4];
   logic [16:0] cur;
   logic [15:0] temp, heat, pin, pout;
   hmd_bridge_t br;
   int n_errors = 0;
   int cmp_count = 0;
   int cmd;
   int nb;

   hmd_motor_drive #(.CTRL_CYCLES(CT), .NSRC(4)) u_hmd_motor_drive (.i_clock(clk),
      .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_q), .i_rd(rd_q),
      .o_rdata(rdata), .i_src(src), .i_current_ma(cur), .i_temp(temp),
      .i_safe_torque_off_input(safe_in), .i_prop1_duty(pin), .o_bridge(br),
      .o_prop1_duty(pout), .o_fault(fault));
   hmd_bridge_model u_hmd_bridge_model (.i_clock(clk), .i_rst_n(rst_n), .i_bridge(br),
      .i_short(shrt), .i_heat(heat), .o_current_ma(cur), .o_temp(temp));

   // Clamp to full scale, then spread over the 16-bit duty range
   function automatic logic [15:0] exp_duty(input int c);
      int m;
      m = (c > `HMD_FULL_SCALE) ? `HMD_FULL_SCALE : c;
      return 16'((m * 32'h0000FFFF) / `HMD_FULL_SCALE);
   endfunction : exp_duty

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_q <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_q <= 1'b0;
   endtask : wr

   // Read data are looked at only in the slot after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_q <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_q <= 1'b0;
      @(negedge clk);
      check(rdata, e);
   endtask : rd

   task automatic ticks(input int n);
      repeat (n * CT) @(posedge clk);
   endtask : ticks

   // Outputs sampled mid-cycle, away from the updating edge
   task automatic bt(input logic e, input logic f, input logic [15:0] d);
      @(negedge clk);
      check({14'h0000, br.enable, br.forward, br.duty}, {14'h0000, e, f, d});
      @(posedge clk);
   endtask : bt

   task automatic flt(input logic e);
      @(negedge clk);
      check(32'(fault), 32'(e));
      @(posedge clk);
   endtask : flt

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   initial begin
      #600000;
      n_errors++;
      complete_run();
   end

   initial begin
      {rst_n, wr_q, rd_q, shrt, addr, wdata, pin} = '0;
      safe_in = 1'b1;
      heat = 16'h0019;
      foreach (src[k]) src[k] = '0;
      void'($urandom(32'hFBDD3C6E));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(`HMD_REG_SRC, 32'h00003210);
      rd(`HMD_REG_RAMP, 32'h00640064);
      rd(`HMD_REG_TEMP, 32'h000A0064);
      rd(`HMD_REG_FILT, 32'h00000403);
      wr(4'hF, 32'h12345678);
      rd(4'hF, 32'h00000000);
      wr(`HMD_REG_RAMP, 32'h00010001);
      safe_in <= 1'b0;
      src[2].value <= 16'sh0001;
      // Random commands, safe input low, prop request passing through
      repeat (4) begin
         cmd = $urandom_range(1, 1000);
         src[0].value <= 16'(cmd);
         pin <= 16'($urandom_range(0, 65535));
         ticks(6);
         bt(1'b1, 1'b1, exp_duty(cmd));
         check(32'(pout), 32'(pin));
      end
      src[0].value <= 16'sh05DC;
      ticks(6);
      bt(1'b1, 1'b1, exp_duty(1500));
      src[3].value <= 16'sh012C;
      wr(`HMD_REG_SRC, 32'h00003213);
      ticks(6);
      bt(1'b1, 1'b1, exp_duty(300));
      wr(`HMD_REG_SRC, 32'h00003210);
      wr(`HMD_REG_CTRL, 32'h00000001);
      ticks(30);
      bt(1'b1, 1'b0, exp_duty(1000));
      wr(`HMD_REG_CTRL, 32'h00000000);
      ticks(30);
      // Reverse request: dead time first, then the other diagonal
      nb = 0;
      src[1].value <= 16'sh0001;
      repeat (30 * CT) begin
         @(negedge clk);
         if (br.brake === 1'b1) nb++;
      end
      check(32'(nb >= 3 * CT), 32'h1);
      bt(1'b1, 1'b0, exp_duty(1000));
      src[1].value <= 16'sh0000;
      ticks(30);
      // Long ramp-down must not delay an enable stop
      wr(`HMD_REG_RAMP, 32'h00640001);
      src[2].value <= 16'sh0000;
      repeat (3) @(posedge clk);
      bt(1'b0, 1'b1, 16'h0000);
      rd(`HMD_REG_DRIVE, 32'h00000000);
      wr(`HMD_REG_RAMP, 32'h00010001);
      src[2].value <= 16'sh0001;
      ticks(6);
      // Over-current latches until the command returns to zero
      shrt <= 1'b1;
      repeat (2) @(posedge clk);
      shrt <= 1'b0;
      ticks(5);
      flt(1'b1);
      src[0].value <= 16'sh0000;
      ticks(3);
      flt(1'b0);
      src[0].value <= 16'sh03E8;
      ticks(6);
      bt(1'b1, 1'b1, exp_duty(1000));
      // Temperature trip and hysteresis boundary
      heat <= 16'h0065;
      ticks(2);
      flt(1'b1);
      heat <= 16'h005A;
      ticks(2);
      flt(1'b1);
      heat <= 16'h0059;
      ticks(2);
      flt(1'b0);
      ticks(6);
      wr(`HMD_REG_LIM_POS, 32'h000007D0);
      ticks(40);
      check(32'(br.duty < 16'hFFFF), 32'h1);
      wr(`HMD_REG_LIM_POS, 32'h0000FFFF);
      // Override source above zero swaps in its own, lower limit
      wr(`HMD_REG_LIM_OVR, 32'h000007D0);
      wr(`HMD_REG_CTRL, 32'h00000002);
      ticks(40);
      check(32'(br.duty < 16'hFFFF), 32'h1);
      // Combined code: off, forward, reverse, reserved
      wr(`HMD_REG_CTRL, 32'h00000004);
      for (int c = 0; c < 4; c++) begin
         src[2].value <= 16'(c);
         ticks(30);
         check({br.enable, br.enable & br.forward},
            (c == 1) ? 2'h3 : (c == 2) ? 2'h2 : 2'h0);
      end
      src[2].value <= 16'sh0001;
      ticks(6);
      bt(1'b1, 1'b1, exp_duty(1000));
      safe_in <= 1'b1;
      ticks(2);
      check({br.enable, pout}, 17'h00000);
      complete_run();
   end
endmodule : tb
